// ==== event_response_pkg.sv ====
// constants, types and register map of the event response block
//
// What this block does
// - first init timeout: back to active with a microcontroller reset
// - second init timeout in a row: enter fault state
// - init timeout nominally 600 ms, within 550 to 650 ms
// - bandgap warning: no state change, interrupt only
// - bandgap fault: enter fault state
// - internal supply under/overvoltage: shut down completely
// - internal supply condition gone: restart into active with reset
// - power-on class registers reset on power-on and disabled entry
// - lock-entry class resets on power-on class events and state_a entry
// - mcu-reset class resets on lock-entry events and every mcu reset
// - read-only bits return value and ignore writes
// - read-write bits store and return written value
// - protected bits read inverted, change only through unlock sequence
// - write-one-clear flags clear on 1, ignore 0, set by hardware
// - self-clearing command bits start operation, hardware clears when done
// - hardware-updated flags set by hardware regardless of software writes
// - any hard reset fault moves active to fault state
// - third hard reset fault moves fault state to state_a
package event_response_pkg;

	typedef enum logic [2:0] {
		st_off,
		st_active,
		st_fault,
		st_a,
		st_disabled
	} dev_state_type;

	// event inputs, one bit each
	typedef struct packed {
		logic wd_increment;
		logic wd_overflow;
		logic bandgap_warn;
		logic bandgap_fault;
		logic io_ov;
		logic io_uv;
		logic io_stg;
		logic prim_ot_warn;
		logic prim_ot_fault;
		logic sec_ot_warn;
		logic sec_ot_fault;
		logic mon_ot_warn;
		logic mon_ot_fault;
	} event_type;

	localparam int CLK_HZ = 10_000_000;
	localparam int INIT_MS = 600;
	localparam int INIT_MIN_MS = 550;
	localparam int INIT_MAX_MS = 650;
	localparam int FAULT_MS = 20;
	localparam int FAULT_TSD_MS = 1000;
	localparam int TRANS_MAX_US = 100;
	localparam int INIT_CYCLES = INIT_MS * (CLK_HZ / 1000);
	localparam int FAULT_CYCLES = FAULT_MS * (CLK_HZ / 1000);
	localparam int FAULT_TSD_CYCLES = FAULT_TSD_MS * (CLK_HZ / 1000);
	localparam int MCU_RESET_CYCLES = 16;
	localparam int CMD_BUSY_CYCLES = 4;

	localparam logic [1:0] HARD_FAULT_LIMIT = 2'h3;

	// register word offsets (byte address)
	localparam logic [7:0] ADDR_STATUS = 8'h00;
	localparam logic [7:0] ADDR_FAULT_FLAGS = 8'h04;
	localparam logic [7:0] ADDR_IRQ_FLAGS = 8'h08;
	localparam logic [7:0] ADDR_CONTROL = 8'h0C;
	localparam logic [7:0] ADDR_PROTECT = 8'h10;
	localparam logic [7:0] ADDR_UNLOCK = 8'h14;
	localparam logic [7:0] ADDR_COMMAND = 8'h18;

	// control fields
	localparam int CTRL_GO_DISABLED = 0;
	localparam int CTRL_GO_STATE_A = 1;
	localparam int CTRL_INIT_DONE = 2;
	// command fields
	localparam int CMD_START = 0;

	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam logic [7:0] PROTECT_RESET = 8'h00;
	localparam logic [7:0] UNLOCK_KEY0 = 8'hAB;
	localparam logic [7:0] UNLOCK_KEY1 = 8'h54;
	localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

endpackage : event_response_pkg

// ==== pmic_event_response_fsm.sv ====
// event response state machine with its avalon-mm register file
//
// The placing of the registers and register access over Avalon-MM are this design's own decisions.
module pmic_event_response_fsm #(
	parameter int INIT_CYCLES = event_response_pkg::INIT_CYCLES,
	parameter int FAULT_CYCLES = event_response_pkg::FAULT_CYCLES,
	parameter int FAULT_TSD_CYCLES = event_response_pkg::FAULT_TSD_CYCLES
) (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire event_response_pkg::event_type events,
	input wire logic internal_supply_bad,
	input wire logic thermal_shutdown,
	input wire logic enable_event,
	output logic mcu_reset_n,
	output logic interrupt_pulse,
	output logic device_on,
	output event_response_pkg::dev_state_type state
);

	// ----------------------------------------------------------------
	// reset release
	// ----------------------------------------------------------------
	logic rst_sync1_reg;
	logic rst_sync2_reg;
	wire logic rst_n = rst_sync2_reg;

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			rst_sync1_reg <= 1'b0;
			rst_sync2_reg <= 1'b0;
		end else begin
			rst_sync1_reg <= 1'b1;
			rst_sync2_reg <= rst_sync1_reg;
		end
	end

	// ----------------------------------------------------------------
	// bus decode
	// ----------------------------------------------------------------
	logic ack_reg;
	wire logic req = (avs_read || avs_write) && !ack_reg;
	// writes land on the edge that ends the wait, never on the first edge
	wire logic wr = avs_write && ack_reg;
	wire logic be0 = avs_byteenable[0];
	wire logic hit_ctrl = wr && be0 && (avs_address == event_response_pkg::ADDR_CONTROL);
	wire logic hit_fflag = wr && be0 && (avs_address == event_response_pkg::ADDR_FAULT_FLAGS);
	wire logic hit_iflag = wr && be0 && (avs_address == event_response_pkg::ADDR_IRQ_FLAGS);
	wire logic hit_unlock = wr && be0 && (avs_address == event_response_pkg::ADDR_UNLOCK);
	wire logic hit_cmd = wr && be0 && (avs_address == event_response_pkg::ADDR_COMMAND);
	wire logic [7:0] wdat = avs_writedata[7:0];
	// one wait cycle: request taken, answer on the next edge
	assign avs_waitrequest = (avs_read || avs_write) && !ack_reg;

	// ----------------------------------------------------------------
	// event classification
	// ----------------------------------------------------------------
	event_response_pkg::event_type ev;
	assign ev = events;
	wire logic init_expired;
	logic init_miss_reg;
	wire logic hard_fault = ev.bandgap_fault || ev.io_ov || ev.io_stg
		|| ev.prim_ot_fault || ev.sec_ot_fault || ev.mon_ot_fault
		|| (init_expired && init_miss_reg);
	wire logic soft_reset = ev.wd_overflow || ev.io_uv
		|| (init_expired && !init_miss_reg);
	wire logic warn_only = ev.wd_increment || ev.bandgap_warn || ev.prim_ot_warn
		|| ev.sec_ot_warn || ev.mon_ot_warn;
	wire logic ot_fault = ev.prim_ot_fault || ev.sec_ot_fault || ev.mon_ot_fault;

	// ----------------------------------------------------------------
	// state machine
	// ----------------------------------------------------------------
	event_response_pkg::dev_state_type state_reg, state_next;
	logic [1:0] hard_count_reg;
	logic [31:0] timer_reg;
	logic tsd_reg;
	logic [7:0] control_reg;
	logic [4:0] rst_cnt_reg;
	wire logic in_active = (state_reg == event_response_pkg::st_active);
	wire logic in_fault = (state_reg == event_response_pkg::st_fault);
	wire logic fault_done = in_fault && (timer_reg == 32'h0000_0000);
	wire logic third_fault = in_fault && (hard_count_reg == event_response_pkg::HARD_FAULT_LIMIT);
	wire logic init_done = control_reg[event_response_pkg::CTRL_INIT_DONE];
	wire logic init_running = in_active && !init_done && (rst_cnt_reg == 5'h00);
	assign init_expired = init_running && (timer_reg == 32'h0000_0000);

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			event_response_pkg::st_off: begin
				if (!internal_supply_bad) state_next = event_response_pkg::st_active;
			end
			event_response_pkg::st_active: begin
				if (hard_fault) state_next = event_response_pkg::st_fault;
				else if (control_reg[event_response_pkg::CTRL_GO_DISABLED])
					state_next = event_response_pkg::st_disabled;
				else if (control_reg[event_response_pkg::CTRL_GO_STATE_A])
					state_next = event_response_pkg::st_a;
			end
			event_response_pkg::st_fault: begin
				if (third_fault) state_next = event_response_pkg::st_a;
				else if (fault_done) state_next = event_response_pkg::st_active;
			end
			event_response_pkg::st_a,
			event_response_pkg::st_disabled: begin
				if (enable_event) state_next = event_response_pkg::st_active;
			end
			default: state_next = event_response_pkg::st_off;
		endcase
		if (internal_supply_bad) state_next = event_response_pkg::st_off;
	end

	wire logic enter_active = (state_next == event_response_pkg::st_active) && !in_active;
	// a reset-type event restarts the microcontroller without leaving active
	wire logic gen_mcu_reset = enter_active
		|| (in_active && soft_reset && state_next == event_response_pkg::st_active);
	wire logic enter_state_a = (state_next == event_response_pkg::st_a)
		&& (state_reg != event_response_pkg::st_a);
	wire logic enter_disabled = (state_next == event_response_pkg::st_disabled)
		&& (state_reg != event_response_pkg::st_disabled);
	wire logic clr_class0 = enter_disabled;
	wire logic clr_class1 = clr_class0 || enter_state_a;
	wire logic clr_class2 = clr_class1 || gen_mcu_reset;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= event_response_pkg::st_active;
		end else begin
			state_reg <= state_next;
		end
	end

	// dwell / init timer; reloads on fault entry, on active entry and on mcu reset
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			timer_reg <= 32'(INIT_CYCLES - 1);
			tsd_reg <= 1'b0;
		end else if (state_next == event_response_pkg::st_fault && !in_fault) begin
			timer_reg <= (thermal_shutdown || ot_fault) ? 32'(FAULT_TSD_CYCLES - 1)
				: 32'(FAULT_CYCLES - 1);
			tsd_reg <= thermal_shutdown || ot_fault;
		end else if (gen_mcu_reset) begin
			timer_reg <= 32'(INIT_CYCLES - 1);
		end else if (timer_reg != 32'h0000_0000 && (in_fault || init_running)) begin
			timer_reg <= timer_reg - 32'h0000_0001;
		end
	end

	// consecutive init misses and hard fault counter
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			init_miss_reg <= 1'b0;
			hard_count_reg <= 2'h0;
		end else begin
			if (init_expired) init_miss_reg <= ~init_miss_reg;
			else if (in_active && init_done) init_miss_reg <= 1'b0;
			if (enter_state_a || enter_disabled) hard_count_reg <= 2'h0;
			else if (in_active && hard_fault) hard_count_reg <= hard_count_reg + 2'h1;
		end
	end

	// microcontroller reset pulse, held low outside active
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rst_cnt_reg <= 5'(event_response_pkg::MCU_RESET_CYCLES);
		end else if (gen_mcu_reset || !in_active) begin
			rst_cnt_reg <= 5'(event_response_pkg::MCU_RESET_CYCLES);
		end else if (rst_cnt_reg != 5'h00) begin
			rst_cnt_reg <= rst_cnt_reg - 5'h01;
		end
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	logic [7:0] fault_flags_reg;
	logic [7:0] irq_flags_reg;
	logic [7:0] protect_reg;
	logic [1:0] unlock_step_reg;
	logic cmd_busy_reg;
	logic [2:0] cmd_cnt_reg;
	wire logic [7:0] fault_set = {2'h0, ev.mon_ot_fault, ev.sec_ot_fault, ev.prim_ot_fault,
		ev.io_stg | ev.io_ov, ev.bandgap_fault, init_expired & init_miss_reg};
	wire logic [7:0] irq_set = {3'h0, ev.mon_ot_warn | ev.sec_ot_warn | ev.prim_ot_warn,
		ev.bandgap_warn, ev.wd_increment, ev.wd_overflow | ev.io_uv, init_expired};

	// fault flags belong to the power-on class, irq flags to lock entry
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			fault_flags_reg <= 8'h00;
			irq_flags_reg <= 8'h00;
		end else begin
			if (clr_class0) fault_flags_reg <= fault_set;
			else fault_flags_reg <= (fault_flags_reg & ~(hit_fflag ? wdat : 8'h00))
				| fault_set;
			if (clr_class1) irq_flags_reg <= irq_set;
			else irq_flags_reg <= (irq_flags_reg & ~(hit_iflag ? wdat : 8'h00))
				| irq_set;
		end
	end

	// control is lock-entry class; state requests self-clear once acted on
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			control_reg <= event_response_pkg::CONTROL_RESET;
		end else if (clr_class1) begin
			control_reg <= event_response_pkg::CONTROL_RESET;
		end else if (hit_ctrl) begin
			control_reg <= wdat;
		end else if (gen_mcu_reset) begin
			control_reg[event_response_pkg::CTRL_INIT_DONE] <= 1'b0;
		end
	end

	// protected byte: two-key unlock, then one write; mcu-reset class
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			protect_reg <= event_response_pkg::PROTECT_RESET;
			unlock_step_reg <= 2'h0;
		end else if (clr_class2) begin
			protect_reg <= event_response_pkg::PROTECT_RESET;
			unlock_step_reg <= 2'h0;
		end else if (hit_unlock) begin
			if (unlock_step_reg == 2'h2) begin
				protect_reg <= wdat;
				unlock_step_reg <= 2'h0;
			end else if (unlock_step_reg == 2'h0 && wdat == event_response_pkg::UNLOCK_KEY0) begin
				unlock_step_reg <= 2'h1;
			end else if (unlock_step_reg == 2'h1 && wdat == event_response_pkg::UNLOCK_KEY1) begin
				unlock_step_reg <= 2'h2;
			end else begin
				unlock_step_reg <= 2'h0;
			end
		end
	end

	// self-clearing command: busy for a fixed count then drops
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cmd_busy_reg <= 1'b0;
			cmd_cnt_reg <= 3'h0;
		end else if (clr_class2) begin
			cmd_busy_reg <= 1'b0;
			cmd_cnt_reg <= 3'h0;
		end else if (hit_cmd && wdat[event_response_pkg::CMD_START] && !cmd_busy_reg) begin
			cmd_busy_reg <= 1'b1;
			cmd_cnt_reg <= 3'(event_response_pkg::CMD_BUSY_CYCLES - 1);
		end else if (cmd_busy_reg) begin
			if (cmd_cnt_reg == 3'h0) cmd_busy_reg <= 1'b0;
			else cmd_cnt_reg <= cmd_cnt_reg - 3'h1;
		end
	end

	// ----------------------------------------------------------------
	// read path
	// ----------------------------------------------------------------
	wire logic [7:0] status_val = {tsd_reg, init_miss_reg, hard_count_reg, 1'b0, state_reg};
	logic [31:0] rd_mux;
	always_comb begin
		if (avs_address == event_response_pkg::ADDR_STATUS) rd_mux = {24'h0, status_val};
		else if (avs_address == event_response_pkg::ADDR_FAULT_FLAGS) rd_mux = {24'h0, fault_flags_reg};
		else if (avs_address == event_response_pkg::ADDR_IRQ_FLAGS) rd_mux = {24'h0, irq_flags_reg};
		else if (avs_address == event_response_pkg::ADDR_CONTROL) rd_mux = {24'h0, control_reg};
		else if (avs_address == event_response_pkg::ADDR_PROTECT) rd_mux = {24'h0, ~protect_reg};
		else if (avs_address == event_response_pkg::ADDR_UNLOCK) rd_mux = {30'h0, unlock_step_reg};
		else if (avs_address == event_response_pkg::ADDR_COMMAND) rd_mux = {31'h0, cmd_busy_reg};
		else rd_mux = event_response_pkg::UNMAPPED_DATA;
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ack_reg <= 1'b0;
			avs_readdata <= 32'h0000_0000;
		end else begin
			ack_reg <= req;
			if (req && avs_read) avs_readdata <= rd_mux;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	logic irq_reg;
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) irq_reg <= 1'b0;
		else irq_reg <= warn_only && in_active;
	end
	assign interrupt_pulse = irq_reg;
	assign mcu_reset_n = in_active && (rst_cnt_reg == 5'h00);
	assign device_on = (state_reg != event_response_pkg::st_off);
	assign state = state_reg;

endmodule : pmic_event_response_fsm

// ==== pmic_event_response_chk.sv ====
// concurrent checks on the ports of the event response block
module pmic_event_response_chk #(
	parameter int FAULT_TSD_CYCLES = event_response_pkg::FAULT_TSD_CYCLES
) (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire event_response_pkg::event_type events,
	input wire logic internal_supply_bad,
	input wire logic thermal_shutdown,
	input wire logic enable_event,
	input wire logic mcu_reset_n,
	input wire logic interrupt_pulse,
	input wire logic device_on,
	input wire event_response_pkg::dev_state_type state
);
	logic [1:0] up_reg;
	logic [7:0] low_reg;
	int fault_reg;
	logic live;
	logic warn_any;
	logic in_active;
	logic in_fault;
	// events are ignored while the internal reset copy is still asserted
	assign live = up_reg == 2'h3;
	assign warn_any = events.wd_increment | events.bandgap_warn | events.prim_ot_warn
		| events.sec_ot_warn | events.mon_ot_warn;
	assign in_active = state == event_response_pkg::st_active;
	assign in_fault = state == event_response_pkg::st_fault;
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			up_reg <= 2'h0;
			low_reg <= 8'h00;
			fault_reg <= 0;
		end else begin
			up_reg <= live ? up_reg : up_reg + 2'h1;
			low_reg <= mcu_reset_n ? 8'h00 : (low_reg == 8'hFF ? low_reg : low_reg + 8'h01);
			fault_reg <= in_fault ? fault_reg + 1 : 0;
		end
	end
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	bus_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest
		|=> !avs_waitrequest) else $error("bus request not answered in its second cycle");
	power_off_a: assert property ((live && internal_supply_bad) [*3] |-> !device_on)
		else $error("device still on with bad internal supply");
	held_reset_a: assert property (!in_active |-> !mcu_reset_n)
		else $error("microcontroller released outside active");
	gap_fault_a: assert property (live && in_active && events.bandgap_fault
		&& !internal_supply_bad |-> ##[1:3] (in_fault || state == event_response_pkg::st_a))
		else $error("bandgap fault ignored");
	rail_fault_a: assert property (live && in_active && (events.io_ov || events.io_stg)
		&& !internal_supply_bad |-> ##[1:3] !in_active) else $error("io rail fault ignored");
	heat_fault_a: assert property (live && in_active && !internal_supply_bad
		&& (events.prim_ot_fault || events.sec_ot_fault || events.mon_ot_fault)
		|-> ##[1:3] !in_active) else $error("overtemperature fault ignored");
	warn_irq_a: assert property (live && in_active && warn_any
		&& !internal_supply_bad |=> interrupt_pulse && in_active)
		else $error("warning gave no interrupt or left active");
	irq_cause_a: assert property (interrupt_pulse |-> $past(warn_any))
		else $error("interrupt without a warning");
	soft_reset_a: assert property (live && in_active && mcu_reset_n
		&& !internal_supply_bad && (events.wd_overflow || events.io_uv)
		|-> ##[1:3] (!mcu_reset_n && in_active))
		else $error("reset event gave no microcontroller reset");
	reset_len_a: assert property ($rose(mcu_reset_n) |->
		low_reg >= 8'(event_response_pkg::MCU_RESET_CYCLES - 1)) else $error("reset pulse too short");
	fault_dwell_a: assert property (in_fault |-> fault_reg <= FAULT_TSD_CYCLES + 4)
		else $error("fault state held too long");
endmodule : pmic_event_response_chk

bind pmic_event_response_fsm pmic_event_response_chk #(.FAULT_TSD_CYCLES(FAULT_TSD_CYCLES)) chk (
	.clk_sys(clk_sys), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
	.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .events(events),
	.internal_supply_bad(internal_supply_bad), .thermal_shutdown(thermal_shutdown),
	.enable_event(enable_event), .mcu_reset_n(mcu_reset_n), .interrupt_pulse(interrupt_pulse),
	.device_on(device_on), .state(state)
);

// ==== mcu_model.sv ====
// microcontroller model: counts the resets and interrupts it receives
module mcu_model (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic mcu_reset_n,
	input wire logic interrupt_pulse,
	output int resets,
	output int irqs,
	output int high_len
);
	timeunit 1ns;
	timeprecision 1ns;
	logic prev_reg;
	int run_reg;
	// sampled on the clock so the x to 0 at start is never taken for a reset
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			prev_reg <= 1'b0;
			run_reg <= 0;
			resets <= 0;
			irqs <= 0;
			high_len <= 0;
		end else begin
			prev_reg <= mcu_reset_n;
			run_reg <= (mcu_reset_n === 1'b1) ? run_reg + 1 : 0;
			if (prev_reg === 1'b1 && mcu_reset_n === 1'b0) begin
				resets <= resets + 1;
				high_len <= run_reg;
			end
			if (interrupt_pulse === 1'b1) begin
				irqs <= irqs + 1;
			end
		end
	end
endmodule : mcu_model

// ==== pmic_event_response_fsm_tb.sv ====
// self-checking bench of the event response block
module pmic_event_response_fsm_tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int INIT_N = 200;
	localparam int FAULT_N = 50;
	localparam int TSD_N = 100;
	logic clk_sys, reset_n, avs_read, avs_write, avs_waitrequest;
	logic [7:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, rd;
	logic [3:0] avs_byteenable;
	event_response_pkg::event_type events;
	logic internal_supply_bad, thermal_shutdown, enable_event;
	logic mcu_reset_n, interrupt_pulse, device_on;
	event_response_pkg::dev_state_type state;
	int n_errors = 0;
	int check_count = 0;
	int cycles = 0;
	int resets, irqs, high_len;
	int fbit[6] = '{9, 8, 6, 4, 2, 0};
	int wbit[5] = '{12, 10, 5, 3, 1};
	pmic_event_response_fsm #(.INIT_CYCLES(INIT_N), .FAULT_CYCLES(FAULT_N), .FAULT_TSD_CYCLES(TSD_N)) dut (
		.clk_sys(clk_sys), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .events(events),
		.internal_supply_bad(internal_supply_bad), .thermal_shutdown(thermal_shutdown),
		.enable_event(enable_event), .mcu_reset_n(mcu_reset_n), .interrupt_pulse(interrupt_pulse),
		.device_on(device_on), .state(state));
	mcu_model mcu (.clk_sys(clk_sys), .reset_n(reset_n), .mcu_reset_n(mcu_reset_n),
		.interrupt_pulse(interrupt_pulse), .resets(resets), .irqs(irqs), .high_len(high_len));
	// ----------------------------------------
	// clock, timeout and shared tasks
	// ----------------------------------------
	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	task automatic print_verdict();
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : print_verdict
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			n_errors++;
			print_verdict();
		end
	end
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask : check
	// holds the request until waitrequest is seen low, then one idle edge
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge clk_sys);
	endtask : bus
	task automatic wait_state(input event_response_pkg::dev_state_type s, input int lim, output int n);
		n = 0;
		while (state !== s && n < lim) begin
			@(posedge clk_sys);
			n++;
		end
	endtask : wait_state
	task automatic pulse(input int b);
		events <= event_response_pkg::event_type'(13'h0001 << b);
		@(posedge clk_sys);
		events <= '0;
		@(posedge clk_sys);
	endtask : pulse
	task automatic kick();
		enable_event <= 1'b1;
		@(posedge clk_sys);
		enable_event <= 1'b0;
		@(posedge clk_sys);
	endtask : kick
	// the init timer would expire again unless software reports init done
	task automatic mcu_ready();
		while (mcu_reset_n !== 1'b1) @(posedge clk_sys);
		bus(1'b1, event_response_pkg::ADDR_CONTROL, 32'h0000_0004);
	endtask : mcu_ready
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		int n, w, dw, off, hard_cnt;
		logic [7:0] pv;
		reset_n = 1'b0;
		{avs_read, avs_write, avs_address, avs_writedata} = '0;
		avs_byteenable = 4'hF;
		events = '0;
		{internal_supply_bad, thermal_shutdown, enable_event} = 3'h0;
		void'($urandom(32'hdb63edc7));
		repeat (3) @(posedge clk_sys);
		reset_n <= 1'b1;
		wait_state(event_response_pkg::st_fault, 2000, n);
		repeat (2) @(posedge clk_sys);
		check(32'(state), 32'(event_response_pkg::st_fault));
		check(32'(resets), 32'h2);
		check(32'(high_len >= INIT_N * 550 / 600 && high_len <= INIT_N * 650 / 600), 32'h1);
		hard_cnt = 1;
		wait_state(event_response_pkg::st_active, FAULT_N + 20, n);
		check(32'(n <= FAULT_N + 4), 32'h1);
		mcu_ready();
		for (int k = 0; k < 2; k++) begin
			pulse((k == 0) ? 11 : 7);
			check(32'(mcu_reset_n), 32'h0);
			check(32'(state), 32'(event_response_pkg::st_active));
			mcu_ready();
		end
		off = $urandom % 5;
		for (int k = 0; k < 5; k++) begin
			w = irqs;
			pulse(wbit[(k + off) % 5]);
			// the model counts on the edge that pulse returns on
			@(posedge clk_sys);
			check(32'(irqs - w), 32'h1);
			check(32'(state), 32'(event_response_pkg::st_active));
		end
		bus(1'b0, event_response_pkg::ADDR_IRQ_FLAGS, '0);
		check(rd & 32'h1C, 32'h1C);
		bus(1'b1, event_response_pkg::ADDR_IRQ_FLAGS, 32'h0);
		bus(1'b0, event_response_pkg::ADDR_IRQ_FLAGS, '0);
		check(rd & 32'h1C, 32'h1C);
		bus(1'b1, event_response_pkg::ADDR_IRQ_FLAGS, 32'hFF);
		bus(1'b0, event_response_pkg::ADDR_IRQ_FLAGS, '0);
		check(rd, 32'h0);
		// lock request clears the lock-entry class
		pulse(wbit[off]);
		bus(1'b1, event_response_pkg::ADDR_CONTROL, 32'h2);
		wait_state(event_response_pkg::st_a, 10, n);
		check(32'(state), 32'(event_response_pkg::st_a));
		bus(1'b0, event_response_pkg::ADDR_IRQ_FLAGS, '0);
		check(rd, 32'h0);
		hard_cnt = 0;
		kick();
		wait_state(event_response_pkg::st_active, 10, n);
		mcu_ready();
		foreach (fbit[i]) begin
			thermal_shutdown <= (i == 0);
			pulse(fbit[i]);
			thermal_shutdown <= 1'b0;
			hard_cnt++;
			dw = (i == 1 || i == 2) ? FAULT_N : TSD_N;
			if (hard_cnt == 3) begin
				wait_state(event_response_pkg::st_a, 10, n);
				check(32'(state), 32'(event_response_pkg::st_a));
				hard_cnt = 0;
				kick();
				wait_state(event_response_pkg::st_active, 10, n);
			end else begin
				wait_state(event_response_pkg::st_fault, 3, n);
				check(32'(state), 32'(event_response_pkg::st_fault));
				wait_state(event_response_pkg::st_active, 2 * TSD_N, n);
				check(32'(n + 5 >= dw && n <= dw + 5), 32'h1);
			end
			check(32'(state), 32'(event_response_pkg::st_active));
			mcu_ready();
		end
		bus(1'b0, 8'h1C, '0);
		check(rd, event_response_pkg::UNMAPPED_DATA);
		bus(1'b1, event_response_pkg::ADDR_STATUS, 32'hFF);
		bus(1'b0, event_response_pkg::ADDR_STATUS, '0);
		check(rd & 32'h7, 32'h1);
		avs_byteenable <= 4'h0;
		bus(1'b1, event_response_pkg::ADDR_CONTROL, 32'h0);
		avs_byteenable <= 4'hF;
		bus(1'b0, event_response_pkg::ADDR_CONTROL, '0);
		check(rd, 32'h4);
		pv = 8'($urandom) | 8'h01;
		bus(1'b1, event_response_pkg::ADDR_PROTECT, {24'h0, pv});
		bus(1'b0, event_response_pkg::ADDR_PROTECT, '0);
		check(rd, 32'hFF);
		bus(1'b1, event_response_pkg::ADDR_UNLOCK, {24'h0, event_response_pkg::UNLOCK_KEY0});
		bus(1'b1, event_response_pkg::ADDR_UNLOCK, {24'h0, event_response_pkg::UNLOCK_KEY1});
		bus(1'b1, event_response_pkg::ADDR_UNLOCK, {24'h0, pv});
		bus(1'b0, event_response_pkg::ADDR_PROTECT, '0);
		check(rd, {24'h0, ~pv});
		pulse(11);
		mcu_ready();
		bus(1'b0, event_response_pkg::ADDR_PROTECT, '0);
		check(rd, 32'hFF);
		bus(1'b1, event_response_pkg::ADDR_COMMAND, 32'h1);
		bus(1'b0, event_response_pkg::ADDR_COMMAND, '0);
		check(rd & 32'h1, 32'h1);
		repeat (8) @(posedge clk_sys);
		bus(1'b0, event_response_pkg::ADDR_COMMAND, '0);
		check(rd & 32'h1, 32'h0);
		bus(1'b0, event_response_pkg::ADDR_FAULT_FLAGS, '0);
		check(rd & 32'h20, 32'h20);
		bus(1'b1, event_response_pkg::ADDR_CONTROL, 32'h1);
		wait_state(event_response_pkg::st_disabled, 10, n);
		bus(1'b0, event_response_pkg::ADDR_FAULT_FLAGS, '0);
		check(rd, 32'h0);
		kick();
		wait_state(event_response_pkg::st_active, 10, n);
		check(32'(mcu_reset_n), 32'h0);
		mcu_ready();
		internal_supply_bad <= 1'b1;
		repeat (5) @(posedge clk_sys);
		check(32'(device_on), 32'h0);
		check(32'(state), 32'(event_response_pkg::st_off));
		internal_supply_bad <= 1'b0;
		wait_state(event_response_pkg::st_active, 20, n);
		check(32'(mcu_reset_n), 32'h0);
		mcu_ready();
		print_verdict();
	end
endmodule : pmic_event_response_fsm_tb
